// ==== logic/gopc_regs.sv ====
// Output steering, frame grouping and pixel path control registers.
// Assumes all inputs synchronous to i_sys_clk; plain register port.
//
// Function
// R1 - Output five selector: host bit, table outputs 0-3, clock, waveform.
// R2 - Output six selector uses the same eight-code encoding.
// R3 - Group 1, 16, 128 or 1024 camera frames per DMA frame.
// R4 - Horizontal jump index loads when line enable asserts.
// R5 - Vertical jump index loads when frame enable asserts.
// R6 - Software writes jump fields as run-length entry indices.
// R7 - Read-only 12-bit firmware revision in bits 11 to 0.
// R8 - Line enable delayed one to eight clocks by trim field.
// R9 - Read-only 4-bit firmware kind in bits 19 to 16.
// R10 - Eight-bit bit keeps only low eight bits of each lane.
// R11 - Clip bit saturates pixels to range 15 to 240.
// R12 - Bit 22 is plain storage with no effect.
// R13 - Bank reset bit holds starting bank at zero.
// R14 - Current starting bank readable in bits 29 to 24.
// R15 - Multiplier code one doubles the active clocks per line.
// R16 - Active clocks per line sets acquisition window length.
// R17 - Reserved selector codes drive low; reserved multiplier unscaled.
// R18 - Read-only fields ignore writes; trim and clip apply at line start.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module gopc_regs
    import gopc_pkg::*;
#(
    parameter int LANES = 2,
    parameter int PIX_W = 16,
    parameter logic [11:0] FW_REVISION = 12'h001, // Arbitrary value
    parameter logic [3:0] FW_KIND = 4'h1 // Arbitrary value
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [gopc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [gopc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [gopc_pkg::DATA_W-1:0] o_rdata,
    // Output steering sources and outputs
    input wire logic i_host_out_five,
    input wire logic i_host_out_six,
    input wire logic [3:0] i_table_out,
    input wire logic i_int_clock,
    input wire logic i_waveform,
    output logic o_general_output_five,
    output logic o_general_output_six,
    // Frame grouping
    input wire logic i_frame_end,
    output logic o_dma_frame_end,
    // Line and frame timing
    input wire logic i_line_enable,
    input wire logic i_frame_enable,
    output logic o_line_enable,
    output logic o_acq_window,
    output logic o_h_jump_load,
    output logic [gopc_pkg::JUMP_W-1:0] o_h_jump_index,
    output logic o_v_jump_load,
    output logic [gopc_pkg::JUMP_W-1:0] o_v_jump_index,
    // Line length
    input wire logic [gopc_pkg::ACTIVE_CLOCKS_PER_LINE_W-1:0] i_active_clocks_per_line,
    output logic [gopc_pkg::ACTIVE_CLOCKS_PER_LINE_W:0] o_line_window_clocks,
    // Pixel path
    input wire logic i_pixel_valid,
    input wire logic [LANES*PIX_W-1:0] i_pixel,
    output logic o_pixel_valid,
    output logic [LANES*PIX_W-1:0] o_pixel,
    // Starting bank
    input wire logic i_bank_update,
    input wire logic [gopc_pkg::BANK_W-1:0] i_bank_calc,
    output logic o_starting_bank_reset,
    output logic [gopc_pkg::BANK_W-1:0] o_starting_bank_value
);

    import gopc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register file
    logic [31:0] steer, next_steer;
    logic [31:0] pixw, next_pixw;
    logic [31:0] next_rdata;
    logic [BANK_W-1:0] next_bank;

    always_comb begin
        next_steer = steer;
        next_pixw = pixw;
        if (i_wr && i_addr == OFS_STEER) begin
            next_steer = i_wdata & STEER_WMASK;
        end
        if (i_wr && i_addr == OFS_PIXEL) begin
            next_pixw = i_wdata & PIXEL_WMASK; // R18 R12
        end
        next_rdata = 32'h0000_0000;
        if (i_rd && i_addr == OFS_STEER) begin
            next_rdata = steer;
        end else if (i_rd && i_addr == OFS_PIXEL) begin
            next_rdata = pixw;
            next_rdata[REV_LSB +: REV_W] = FW_REVISION; // R7
            next_rdata[KIND_LSB +: KIND_W] = FW_KIND; // R9
            next_rdata[BANK_LSB +: BANK_W] = o_starting_bank_value; // R14
        end
        next_bank = o_starting_bank_value;
        if (pixw[BANK_RST_BIT]) begin
            next_bank = '0; // R13
        end else if (i_bank_update) begin
            next_bank = i_bank_calc;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            steer <= STEER_RST;
            pixw <= PIXEL_RST;
            o_rdata <= 32'h0000_0000;
            o_starting_bank_value <= '0;
        end else begin
            steer <= next_steer;
            pixw <= next_pixw;
            o_rdata <= next_rdata;
            o_starting_bank_value <= next_bank;
        end
    end

    assign o_starting_bank_reset = pixw[BANK_RST_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Output steering; code 7 picks the constant low entry
    logic [2:0] sel5, sel6;
    logic [7:0] src5, src6;
    logic next_out5, next_out6;

    always_comb begin
        sel5 = steer[SEL5_LSB +: SEL_W];
        sel6 = steer[SEL6_LSB +: SEL_W];
        src5 = {1'b0, i_waveform, i_int_clock, i_table_out, i_host_out_five};
        src6 = {1'b0, i_waveform, i_int_clock, i_table_out, i_host_out_six};
        next_out5 = src5[sel5]; // R1 R17
        next_out6 = src6[sel6]; // R2 R17
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_general_output_five <= 1'b0;
            o_general_output_six <= 1'b0;
        end else begin
            o_general_output_five <= next_out5;
            o_general_output_six <= next_out6;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Camera frames to DMA frames
    logic [10:0] grp_cnt, next_grp_cnt, grp_target;
    logic next_dma_end;

    always_comb begin
        unique case (steer[GROUP_LSB +: 2])
            2'h0: grp_target = GROUP_N0;
            2'h1: grp_target = GROUP_N1;
            2'h2: grp_target = GROUP_N2;
            2'h3: grp_target = GROUP_N3;
        endcase
        next_dma_end = i_frame_end && (grp_cnt + 11'h001 >= grp_target); // R3
        next_grp_cnt = grp_cnt;
        if (next_dma_end) begin
            next_grp_cnt = 11'h000;
        end else if (i_frame_end) begin
            next_grp_cnt = grp_cnt + 11'h001;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            grp_cnt <= 11'h000;
            o_dma_frame_end <= 1'b0;
        end else begin
            grp_cnt <= next_grp_cnt;
            o_dma_frame_end <= next_dma_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line timing, jumps, trim and acquisition window
    logic line_prev, frame_prev, dline_prev, line_start, frame_start;
    logic [2:0] active_trim, next_trim, trim_sat;
    logic active_clip, next_clip;
    logic next_h_load, next_v_load;
    logic [JUMP_W-1:0] next_h_idx, next_v_idx;
    logic [ACTIVE_CLOCKS_PER_LINE_W:0] win_cnt, next_win_cnt, next_win_len;
    logic next_acq;

    always_comb begin
        line_start = i_line_enable & ~line_prev;
        frame_start = i_frame_enable & ~frame_prev;
        trim_sat = pixw[TRIM_LSB+3] ? TRIM_MAX : pixw[TRIM_LSB +: 3];
        next_trim = line_start ? trim_sat : active_trim; // R18 R8
        next_clip = line_start ? pixw[CLIP_BIT] : active_clip; // R18
        next_h_load = line_start; // R4
        next_h_idx = line_start ? steer[HJUMP_LSB +: JUMP_W] : o_h_jump_index;
        next_v_load = frame_start; // R5
        next_v_idx = frame_start ? steer[VJUMP_LSB +: JUMP_W] : o_v_jump_index;
        next_win_len = (pixw[MUL_LSB +: 2] == MUL_DOUBLE) // R15 R17
            ? {i_active_clocks_per_line, 1'b0}
            : {1'b0, i_active_clocks_per_line};
        next_win_cnt = win_cnt;
        if (o_line_enable && !dline_prev) begin
            next_win_cnt = o_line_window_clocks; // R16
        end else if (win_cnt != '0) begin
            next_win_cnt = win_cnt - 1'b1;
        end
        next_acq = next_win_cnt != '0;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            line_prev <= 1'b0;
            frame_prev <= 1'b0;
            dline_prev <= 1'b0;
            active_trim <= 3'h0;
            active_clip <= 1'b0;
            o_h_jump_load <= 1'b0;
            o_h_jump_index <= '0;
            o_v_jump_load <= 1'b0;
            o_v_jump_index <= '0;
            o_line_window_clocks <= '0;
            win_cnt <= '0;
            o_acq_window <= 1'b0;
        end else begin
            line_prev <= i_line_enable;
            frame_prev <= i_frame_enable;
            dline_prev <= o_line_enable;
            active_trim <= next_trim;
            active_clip <= next_clip;
            o_h_jump_load <= next_h_load;
            o_h_jump_index <= next_h_idx;
            o_v_jump_load <= next_v_load;
            o_v_jump_index <= next_v_idx;
            o_line_window_clocks <= next_win_len;
            win_cnt <= next_win_cnt;
            o_acq_window <= next_acq;
        end
    end

    gopc_line_delay #(.DEPTH(TRIM_DEPTH)) u_line_delay (
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_line(i_line_enable),
        .i_delay(next_trim),
        .o_line(o_line_enable)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pixel path: eight-bit mask then clip, one register stage
    logic [LANES-1:0][PIX_W-1:0] lane_next;
    logic chk_clip, chk_eight;

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_comb begin
            logic [PIX_W-1:0] v;
            v = i_pixel[g*PIX_W +: PIX_W];
            if (pixw[EIGHT_BIT]) begin
                v = {{(PIX_W-8){1'b0}}, v[7:0]}; // R10
            end
            if (next_clip && v > PIX_W'(CLIP_HI)) begin
                v = PIX_W'(CLIP_HI); // R11
            end else if (next_clip && v < PIX_W'(CLIP_LO)) begin
                v = PIX_W'(CLIP_LO); // R11
            end
            lane_next[g] = v;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pixel <= '0;
            o_pixel_valid <= 1'b0;
            chk_clip <= 1'b0;
            chk_eight <= 1'b0;
        end else begin
            o_pixel <= lane_next;
            o_pixel_valid <= i_pixel_valid;
            chk_clip <= next_clip;
            chk_eight <= pixw[EIGHT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    AST_SEL5_RSVD: assert property ( // R1
        sel5 == SEL_RSVD |=> !o_general_output_five)
        else $error("reserved selector five not low");
    AST_SEL6_CLOCK: assert property ( // R2
        sel6 == SEL_CLOCK |=> o_general_output_six == $past(i_int_clock))
        else $error("selector six clock not steered");
    AST_GROUP_SINGLE: assert property ( // R3
        steer[GROUP_LSB +: 2] == 2'h0 && i_frame_end |=> o_dma_frame_end)
        else $error("single frame group missed");
    AST_H_JUMP: assert property ( // R4
        line_start |=> o_h_jump_load &&
        o_h_jump_index == $past(steer[HJUMP_LSB +: JUMP_W]))
        else $error("horizontal jump not loaded");
    AST_V_JUMP: assert property ( // R5
        frame_start |=> o_v_jump_load &&
        o_v_jump_index == $past(steer[VJUMP_LSB +: JUMP_W]))
        else $error("vertical jump not loaded");
    AST_TRIM_TWO: assert property ( // R8
        (line_start && next_trim == 3'h2) ##1 (!line_start) [*2]
        |=> o_line_enable)
        else $error("trim two delay wrong");
    AST_CLIP: assert property ( // R11
        o_pixel_valid && chk_clip |->
        o_pixel[PIX_W-1:0] <= PIX_W'(CLIP_HI) &&
        o_pixel[PIX_W-1:0] >= PIX_W'(CLIP_LO))
        else $error("clipped pixel out of range");
    AST_EIGHT: assert property ( // R10
        o_pixel_valid && chk_eight |-> o_pixel[PIX_W-1:8] == '0)
        else $error("eight-bit lane has upper bits");
    AST_BANK_RST: assert property ( // R13
        pixw[BANK_RST_BIT] |=> o_starting_bank_value == '0)
        else $error("starting bank not held in reset");
    AST_MUL: assert property ( // R15
        pixw[MUL_LSB +: 2] == MUL_DOUBLE |=>
        o_line_window_clocks == {$past(i_active_clocks_per_line), 1'b0})
        else $error("line count not doubled");
    AST_REV_READ: assert property ( // R7
        i_rd && i_addr == OFS_PIXEL |=> o_rdata[11:0] == FW_REVISION)
        else $error("firmware revision readback wrong");

    COV_GROUP_END: cover property (o_dma_frame_end);
    COV_TRIM_LINE: cover property (line_start && next_trim == TRIM_MAX);
    COV_CLIP_PIX: cover property (o_pixel_valid && chk_clip);
    COV_WINDOW: cover property (o_acq_window ##1 !o_acq_window);

endmodule

// ==== common/gopc_pkg.sv ====
// Constants for the output steering and pixel path control registers.
// Assumes a single 125 MHz system clock and a plain register port.
package gopc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_STEER = 8'h00;
    localparam logic [7:0] OFS_PIXEL = 8'h04;
    localparam logic [31:0] STEER_RST = 32'h0000_0000;
    localparam logic [31:0] PIXEL_RST = 32'h0000_0000;
    // Bit 23 of the steering word reads as zero
    localparam logic [31:0] STEER_WMASK = 32'hFF7F_FFFF;
    // Only trim, eight-bit, clip, spare, bank reset and multiplier store
    localparam logic [31:0] PIXEL_WMASK = 32'hC0F0_F000;

    ////////////////////////////////////////////////////////////////////////
    // Steering word fields
    localparam int SEL_W = 3;
    localparam int SEL5_LSB = 15;
    localparam int SEL6_LSB = 18;
    localparam int GROUP_LSB = 21;
    localparam int HJUMP_LSB = 24;
    localparam int VJUMP_LSB = 28;
    localparam int JUMP_W = 4;

    ////////////////////////////////////////////////////////////////////////
    // Pixel path word fields
    localparam int REV_LSB = 0;
    localparam int REV_W = 12;
    localparam int TRIM_LSB = 12;
    localparam int KIND_LSB = 16;
    localparam int KIND_W = 4;
    localparam int EIGHT_BIT = 20;
    localparam int CLIP_BIT = 21;
    localparam int SPARE_BIT = 22;
    localparam int BANK_RST_BIT = 23;
    localparam int BANK_LSB = 24;
    localparam int BANK_W = 6;
    localparam int MUL_LSB = 30;
    localparam logic [1:0] MUL_DOUBLE = 2'h1;

    ////////////////////////////////////////////////////////////////////////
    // Pixel path constants
    localparam int TRIM_DEPTH = 8;
    localparam logic [2:0] TRIM_MAX = 3'h7;
    localparam int CLIP_HI = 32'h0000_00F0;
    localparam int CLIP_LO = 32'h0000_000F;
    localparam int ACTIVE_CLOCKS_PER_LINE_W = 17;

    ////////////////////////////////////////////////////////////////////////
    // Camera frames per DMA frame, by grouping code
    localparam logic [10:0] GROUP_N0 = 11'h001;
    localparam logic [10:0] GROUP_N1 = 11'h010;
    localparam logic [10:0] GROUP_N2 = 11'h080;
    localparam logic [10:0] GROUP_N3 = 11'h400;

    typedef enum logic [2:0] {
        SEL_HOST,
        SEL_TAB0,
        SEL_TAB1,
        SEL_TAB2,
        SEL_TAB3,
        SEL_CLOCK,
        SEL_WAVE,
        SEL_RSVD
    } gopc_sel_t;

endpackage

// ==== logic/gopc_line_delay.sv ====
// Programmable delay line for the line enable, whole clocks.
// Assumes the delay select only changes at a line start.
`timescale 1ns/1ps
module gopc_line_delay #(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Line in, delay, line out
    input wire logic i_line,
    input wire logic [$clog2(DEPTH)-1:0] i_delay,
    output logic o_line
);

    logic [DEPTH-2:0] taps;
    logic [DEPTH-2:0] next_taps;
    logic next_line;

    always_comb begin
        next_taps = {taps[DEPTH-3:0], i_line};
        if (i_delay == '0) begin
            next_line = i_line;
        end else begin
            next_line = taps[i_delay - 1'b1];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            taps <= '0;
            o_line <= 1'b0;
        end else begin
            taps <= next_taps;
            o_line <= next_line;
        end
    end

endmodule

// ==== tb/gopc_regs_test.sv ====
// Self-checking bench for the steering and pixel path control registers.
// Assumes gopc_pkg compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module gopc_regs_test;
    import gopc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [6:0] src = 7'h00;
    logic fend = 1'b0;
    logic lin = 1'b0;
    logic frame_enable = 1'b0;
    logic pv = 1'b0;
    logic [31:0] pd = 32'h0000_0000;
    logic bupd = 1'b0;
    logic [5:0] bcalc = 6'h2A;
    logic [31:0] rdata, pix_o;
    logic out5, out6, dma_end, line_o, win, hload, vload, pv_o, brst;
    logic [3:0] hidx, vidx;
    logic [17:0] wclk;
    logic [5:0] bank;
    logic [31:0] d, q;
    logic [16:0] active_clocks_per_line = 17'h00005;
    int n_errors = 0;
    int checked = 0;
    int n_dma = 0;
    int n_win = 0;
    int k;
    int grp[4] = '{1, 16, 128, 1024};
    // Identity values below are arbitrary
    localparam logic [31:0] ID = 32'h0006_0A5C;

    gopc_regs #(.FW_REVISION(12'hA5C), .FW_KIND(4'h6)) dut_u (
        .i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata),
        .i_host_out_five(src[0]), .i_host_out_six(src[0]),
        .i_table_out(src[4:1]), .i_int_clock(src[5]),
        .i_waveform(src[6]),
        .o_general_output_five(out5), .o_general_output_six(out6),
        .i_frame_end(fend), .o_dma_frame_end(dma_end),
        .i_line_enable(lin), .i_frame_enable(frame_enable),
        .o_line_enable(line_o), .o_acq_window(win),
        .o_h_jump_load(hload), .o_h_jump_index(hidx),
        .o_v_jump_load(vload), .o_v_jump_index(vidx),
        .i_active_clocks_per_line(active_clocks_per_line),
        .o_line_window_clocks(wclk),
        .i_pixel_valid(pv), .i_pixel(pd),
        .o_pixel_valid(pv_o), .o_pixel(pix_o),
        .i_bank_update(bupd), .i_bank_calc(bcalc),
        .o_starting_bank_reset(brst), .o_starting_bank_value(bank)
    );

    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    always @(posedge i_sys_clk) begin
        if (dma_end === 1'b1) n_dma++;
        if (win === 1'b1) n_win++;
    end

    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge i_sys_clk);
        wr <= 1'b0;
    endtask

    task rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge i_sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task fpulse;
        @(posedge i_sys_clk);
        fend <= 1'b1;
        @(posedge i_sys_clk);
        fend <= 1'b0;
    endtask

    task bpulse;
        @(posedge i_sys_clk);
        bupd <= 1'b1;
        @(posedge i_sys_clk);
        bupd <= 1'b0;
        #1;
    endtask

    function automatic logic [15:0] lane(logic [15:0] v, logic e, logic c);
        logic [15:0] r;
        r = e ? {8'h00, v[7:0]} : v;
        if (c && r > 16'h00F0) r = 16'h00F0;
        if (c && r < 16'h000F) r = 16'h000F;
        return r;
    endfunction

    task end_of_test;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rreg(OFS_STEER, d);
        chk(d, 32'h0000_0000);
        rreg(OFS_PIXEL, d);
        chk(d, ID);
        rreg(8'h08, d);
        chk(d, 32'h0000_0000);
        $display("reset values done");
        // Selected source alone high, then alone low
        for (int c = 0; c < 8; c++) begin
            wreg(OFS_STEER, (32'(c) << SEL5_LSB) | (32'(c) << SEL6_LSB));
            for (int p = 0; p < 2; p++) begin
                @(posedge i_sys_clk);
                src <= (c == 7) ? 7'h7F :
                       (p == 1) ? ~(7'h01 << c) : (7'h01 << c);
                repeat (2) @(posedge i_sys_clk);
                #1;
                chk(out5, (c < 7 && p == 0));
                chk(out6, (c < 7 && p == 0));
            end
        end
        $display("selectors done");
        for (int g = 0; g < 4; g++) begin
            wreg(OFS_STEER, 32'(g) << GROUP_LSB);
            n_dma = 0;
            repeat (grp[g] - 1) fpulse;
            repeat (3) @(posedge i_sys_clk);
            chk(n_dma, 0);
            fpulse;
            repeat (3) @(posedge i_sys_clk);
            chk(n_dma, 1);
        end
        $display("frame grouping done");
        wreg(OFS_STEER, 32'h5A00_0000);
        @(posedge i_sys_clk);
        frame_enable <= 1'b1;
        @(posedge i_sys_clk);
        #1;
        chk(vload, 1'b1);
        chk(vidx, 4'h5);
        @(posedge i_sys_clk);
        frame_enable <= 1'b0;
        for (int t = 0; t < 8; t++) begin
            // Last pass writes trim 15, which must act as seven
            d = (32'(t >> 1) << MUL_LSB)
                | (32'((t == 7) ? 15 : t) << TRIM_LSB)
                | (32'(t & 1) << EIGHT_BIT) | (32'(t & 1) << SPARE_BIT)
                | (32'((t >> 1) & 1) << CLIP_BIT);
            wreg(OFS_PIXEL, d);
            rreg(OFS_PIXEL, q);
            chk(q, d | ID);
            n_win = 0;
            k = 0;
            @(posedge i_sys_clk);
            lin <= 1'b1;
            active_clocks_per_line <= 17'(5 + t);
            do begin
                @(posedge i_sys_clk);
                #1;
                k++;
                if (k == 1) chk(hload, 1'b1);
                if (k == 1) chk(hidx, 4'hA);
            end while (line_o !== 1'b1 && k < 20);
            chk(k, 1 + t);
            chk(wclk, ((t >> 1) == 1) ? 2 * (5 + t) : 5 + t);
            @(posedge i_sys_clk);
            pv <= 1'b1;
            pd <= 32'h1234_0005;
            @(posedge i_sys_clk);
            pv <= 1'b0;
            #1;
            chk(pv_o, 1'b1);
            chk(pix_o, {lane(16'h1234, t & 1, (t >> 1) & 1),
                        lane(16'h0005, t & 1, (t >> 1) & 1)});
            repeat (25) @(posedge i_sys_clk);
            lin <= 1'b0;
            repeat (5) @(posedge i_sys_clk);
            chk(n_win, ((t >> 1) == 1) ? 2 * (5 + t) : 5 + t);
        end
        $display("line timing and pixel path done");
        bpulse;
        chk(bank, 6'h2A);
        rreg(OFS_PIXEL, d);
        chk(d[29:24], 6'h2A);
        wreg(OFS_PIXEL, 32'hFFFF_FFFF);
        rreg(OFS_PIXEL, d);
        chk(d, 32'hC0F0_F000 | ID);
        chk(brst, 1'b1);
        bpulse;
        chk(bank, 6'h00);
        wreg(OFS_STEER, 32'hFFFF_FFFF);
        rreg(OFS_STEER, d);
        chk(d, 32'hFF7F_FFFF);
        $display("bank and read-only done");
        @(posedge i_sys_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        rreg(OFS_PIXEL, d);
        chk(d, ID);
        chk(brst, 1'b0);
        $display("second reset done");
        end_of_test;
    end
endmodule
